// File: hw/cci_pkg.sv
package cci_pkg;

    // ************************************************************
    // special function register addresses
    // ************************************************************
    localparam logic [7:0] CMD_PORT_ADDR = 8'hDD;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hDF;
    localparam logic [7:0] IRQ_FLAGS_ADDR = 8'hE7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] IRQ_MASK_RESET = 8'hFF;
    localparam logic [7:0] CMD_PORT_RESET = 8'hFF;
    localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;

    // ************************************************************
    // flag and mask bit positions
    // ************************************************************
    localparam int CARD_BUSY_BIT = 7;
    localparam int RESPONSE_END_BIT = 6;
    localparam int COMMAND_END_BIT = 5;
    localparam int FRAME_END_BIT = 4;
    localparam int FIFO_B_FULL_BIT = 3;
    localparam int FIFO_A_FULL_BIT = 2;
    localparam int FIFO_B_EMPTY_BIT = 1;
    localparam int FIFO_A_EMPTY_BIT = 0;

    // event flags cleared by a read of the flag register
    localparam logic [7:0] READ_CLEAR_MASK = 8'hF0;

endpackage

// File: hw/cci_regs.sv
module cci_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic card_busy,
    input wire logic command_done,
    input wire logic response_done,
    input wire logic frame_done,
    input wire logic fifo_a_full,
    input wire logic fifo_a_empty,
    input wire logic fifo_b_full,
    input wire logic fifo_b_empty,
    input wire logic [7:0] response_byte,
    output logic response_pop,
    output logic [7:0] command_byte_bits,
    output logic command_load,
    output logic card_irq
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        // software visible registers
        logic [7:0] card_irq_flags;
        logic [7:0] card_irq_mask;
        logic [7:0] card_command_port;
        // one-cycle strobes and registered read data
        logic command_load;
        logic response_pop;
        logic [7:0] rdata;
        // status levels of the last cycle, for edge detection
        logic busy_seen;
        logic a_full_seen;
        logic a_empty_seen;
        logic b_full_seen;
        logic b_empty_seen;
        // registered controller interrupt request
        logic irq;
    } cci_state_type;

    // registered state and its next value
    cci_state_type state;
    cci_state_type next_state;

    // ************************************************************
    // helper functions
    // ************************************************************

    // rising edge of a level against its registered copy
    function automatic logic cci_rise(input logic now, input logic was);
        cci_rise = now & ~was;
    endfunction

    // any change of a level against its registered copy
    function automatic logic cci_toggle(input logic now, input logic was);
        cci_toggle = now ^ was;
    endfunction

    // register bus address against the address of one register
    function automatic logic cci_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        cci_hit = (addr == reg_addr);
    endfunction

    // sticky flags; a new event wins over a clear in the same cycle
    function automatic logic [7:0] cci_merge(
        input logic [7:0] old_flags,
        input logic [7:0] set_mask,
        input logic [7:0] clr_mask
    );
        cci_merge = (old_flags & ~clr_mask) | set_mask;
    endfunction

    // one request line from the flags that their mask bits let through
    function automatic logic cci_request(input logic [7:0] flags, input logic [7:0] mask);
        cci_request = |(flags & ~mask);
    endfunction

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic [7:0] set_bits;
        logic [7:0] clr_bits;
        logic [7:0] flags;
        logic rd_flags;
        logic busy_change;
        logic a_full_rise;
        logic a_empty_rise;
        logic b_full_rise;
        logic b_empty_rise;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        flags = 8'h00;
        next_state = state;
        rd_flags = sfr_rd && cci_hit(sfr_addr, cci_pkg::IRQ_FLAGS_ADDR);

        // edges of the status levels against the last cycle
        busy_change = cci_toggle(card_busy, state.busy_seen);
        a_full_rise = cci_rise(fifo_a_full, state.a_full_seen);
        a_empty_rise = cci_rise(fifo_a_empty, state.a_empty_seen);
        b_full_rise = cci_rise(fifo_b_full, state.b_full_seen);
        b_empty_rise = cci_rise(fifo_b_empty, state.b_empty_seen);

        // ************************************************************
        // edge history
        // ************************************************************
        // remember input levels for edge detection
        next_state.busy_seen = card_busy;
        next_state.a_full_seen = fifo_a_full;
        next_state.a_empty_seen = fifo_a_empty;
        next_state.b_full_seen = fifo_b_full;
        next_state.b_empty_seen = fifo_b_empty;

        // ************************************************************
        // interrupt flags
        // ************************************************************
        // hardware event sources
        set_bits[cci_pkg::CARD_BUSY_BIT] = busy_change;
        set_bits[cci_pkg::RESPONSE_END_BIT] = response_done;
        set_bits[cci_pkg::COMMAND_END_BIT] = command_done;
        set_bits[cci_pkg::FRAME_END_BIT] = frame_done;
        // fifo level changes; full and empty of one fifo exclude each other
        set_bits[cci_pkg::FIFO_A_FULL_BIT] = a_full_rise;
        set_bits[cci_pkg::FIFO_B_FULL_BIT] = b_full_rise;
        set_bits[cci_pkg::FIFO_A_EMPTY_BIT] = a_empty_rise;
        set_bits[cci_pkg::FIFO_B_EMPTY_BIT] = b_empty_rise;
        clr_bits[cci_pkg::FIFO_A_FULL_BIT] = a_empty_rise;
        clr_bits[cci_pkg::FIFO_B_FULL_BIT] = b_empty_rise;
        clr_bits[cci_pkg::FIFO_A_EMPTY_BIT] = a_full_rise;
        clr_bits[cci_pkg::FIFO_B_EMPTY_BIT] = b_full_rise;

        // read of the flag register clears only the event flags
        if (rd_flags) begin
            clr_bits = clr_bits | cci_pkg::READ_CLEAR_MASK;
        end

        // a new event wins over a clear in the same cycle
        flags = cci_merge(state.card_irq_flags, set_bits, clr_bits);
        next_state.card_irq_flags = flags;

        // ************************************************************
        // register writes
        // ************************************************************
        // the flag address and unmapped addresses take no write
        next_state.command_load = 1'h0;
        if (sfr_wr) begin
            case (sfr_addr)
                cci_pkg::IRQ_MASK_ADDR: begin
                    next_state.card_irq_mask = sfr_wdata;
                end
                cci_pkg::CMD_PORT_ADDR: begin
                    next_state.card_command_port = sfr_wdata;
                    next_state.command_load = 1'h1;
                end
                default: begin
                    next_state.card_irq_mask = state.card_irq_mask;
                end
            endcase
        end

        // ************************************************************
        // register reads
        // ************************************************************
        // read data follows the address; only a strobed command read pops
        next_state.response_pop = 1'h0;
        case (sfr_addr)
            cci_pkg::IRQ_FLAGS_ADDR: next_state.rdata = state.card_irq_flags;
            cci_pkg::IRQ_MASK_ADDR: next_state.rdata = state.card_irq_mask;
            cci_pkg::CMD_PORT_ADDR: begin
                next_state.rdata = response_byte;
                next_state.response_pop = sfr_rd;
            end
            default: next_state.rdata = 8'h00;
        endcase

        // ************************************************************
        // interrupt request
        // ************************************************************
        // unmasked flags request the controller interrupt
        next_state.irq = cci_request(flags, next_state.card_irq_mask);
    end

    // ************************************************************
    // state register
    // ************************************************************
    // synchronous reset; otherwise every register takes its next value
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
            state.card_irq_flags <= cci_pkg::IRQ_FLAGS_RESET;
            state.card_irq_mask <= cci_pkg::IRQ_MASK_RESET;
            state.card_command_port <= cci_pkg::CMD_PORT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // outputs straight from flip-flops
    // ************************************************************
    assign sfr_rdata = state.rdata;
    assign response_pop = state.response_pop;
    assign command_byte_bits = state.card_command_port;
    assign command_load = state.command_load;
    assign card_irq = state.irq;

endmodule

// File: tb/cci_card_model.sv
module cci_card_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic response_pop,
    input wire logic command_load,
    input wire logic [7:0] command_byte_bits,
    output logic [7:0] response_byte,
    output logic [7:0] last_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    // response head advances per pop, commands are captured
    always_ff @(posedge clock) begin
        if (rst) begin
            response_byte <= 8'hA0;
            last_cmd <= 8'h00;
        end else begin
            if (response_pop) response_byte <= response_byte + 8'h01;
            if (command_load) last_cmd <= command_byte_bits;
        end
    end
endmodule

// File: tb/cci_regs_assertions.sv
module cci_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic card_busy,
    input wire logic command_done,
    input wire logic [7:0] response_byte,
    input wire logic response_pop,
    input wire logic [7:0] command_byte_bits,
    input wire logic command_load,
    input wire logic card_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] msk;
    logic mw, cw, cr;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // decoded accesses and a shadow of the mask
    assign mw = sfr_wr && sfr_addr == 8'hDF;
    assign cw = sfr_wr && sfr_addr == 8'hDD;
    assign cr = sfr_rd && sfr_addr == 8'hDD;
    always_ff @(posedge clock) begin
        msk <= rst ? 8'hFF : (mw ? sfr_wdata : msk);
    end
    sequence s_cmd_once;
        cw ##1 !cw;
    endsequence
    a_cmd_load: assert property (s_cmd_once |-> command_load &&
        command_byte_bits == $past(sfr_wdata) ##1 !command_load) else $error("cmd load");
    a_cmd_hold: assert property (!cw |=> $stable(command_byte_bits) && !command_load)
        else $error("cmd hold");
    a_pop_data: assert property (cr |=> response_pop && sfr_rdata == $past(response_byte))
        else $error("pop data");
    a_busy_irq: assert property ($changed(card_busy) && !msk[7] && !mw |=> card_irq)
        else $error("busy irq");
    a_done_irq: assert property (command_done && !msk[5] && !mw |=> card_irq)
        else $error("done irq");
    a_mask_all: assert property (msk == 8'hFF && !mw |=> !card_irq) else $error("masked");
    a_mask_read: assert property (sfr_addr == 8'hDF && !sfr_wr |=> sfr_rdata == $past(msk))
        else $error("mask read");
    a_irq_source: assert property (card_irq |-> msk != 8'hFF) else $error("irq src");
endmodule
bind cci_regs cci_checker u_chk (.*);

// File: tb/test_card_ctrl_irq_cmd_regs.sv
module test_card_ctrl_irq_cmd_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, response_byte, command_byte_bits, last_cmd;
    logic clock, rst, sfr_wr, sfr_rd, card_busy, command_done, response_done, frame_done;
    logic fifo_a_full, fifo_a_empty, fifo_b_full, fifo_b_empty, response_pop, command_load, card_irq;
    int err_total, checked;
    cci_regs DUT (.*);
    cci_card_model u_card (.*);
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'h1, a, d};
        @(negedge clock);
        sfr_wr = 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clock);
        {sfr_rd, sfr_addr} = {1'h1, a};
        @(negedge clock);
        sfr_rd = 1'h0;
        chk("rdata", sfr_rdata, exp);
    endtask
    task automatic finish_test();
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // clock and watchdog
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    // register sequence
    initial begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, card_busy, command_done, response_done} = '0;
        {frame_done, fifo_a_full, fifo_a_empty, fifo_b_full, fifo_b_empty} = '0;
        {rst, err_total, checked} = {1'h1, 32'h0, 32'h0};
        repeat (4) @(negedge clock);
        rst = 1'h0;
        rd(8'hDF, 8'hFF);
        chk("cmd", command_byte_bits, 8'hFF);
        rd(8'hDD, 8'hA0);
        rd(8'hE7, 8'h00);
        wr(8'hDF, 8'h00);
        card_busy = 1'h1;
        @(negedge clock);
        chk("irq", {7'h00, card_irq}, 8'h01);
        rd(8'hE7, 8'h80);
        rd(8'hE7, 8'h00);
        card_busy = 1'h0;
        rd(8'hE7, 8'h80);
        for (int i = 0; i < 3; i++) begin
            {response_done, command_done, frame_done} = 3'h1 << i;
            @(negedge clock);
            {response_done, command_done, frame_done} = 3'h0;
            rd(8'hE7, 8'h10 << i);
        end
        fifo_a_empty = 1'b1;
        rd(8'hE7, 8'h01);
        rd(8'hE7, 8'h01);
        {fifo_a_empty, fifo_a_full, fifo_b_empty} = 3'h3;
        rd(8'hE7, 8'h06);
        {fifo_a_empty, fifo_a_full, fifo_b_empty, fifo_b_full} = 4'h9;
        rd(8'hE7, 8'h09);
        wr(8'hDF, 8'hFD);
        chk("irq", {7'h00, card_irq}, 8'h00);
        wr(8'hDF, 8'hF7);
        chk("irq", {7'h00, card_irq}, 8'h01);
        wr(8'hE7, 8'h00);
        rd(8'hE7, 8'h09);
        rd(8'hDF, 8'hF7);
        wr(8'hDD, 8'h5A);
        chk("cmd", command_byte_bits, 8'h5A);
        rd(8'hDD, 8'hA1);
        chk("card", last_cmd, 8'h5A);
        finish_test();
    end
endmodule
